// ---- hdl/split_timer_pkg.sv ----
// Package: register map, field positions, encodings and divider counts of the split timer
package split_timer_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COUNT_LOW = 8'h04;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h08;
  localparam logic [7:0] OFF_RELOAD_LOW = 8'h0c;
  localparam logic [7:0] OFF_RELOAD_HIGH = 8'h10;
  localparam logic [7:0] OFF_CLOCK_CONTROL = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;

  // Timer control register fields
  localparam int CTL_HIGH_FLAG = 7;
  localparam int CTL_LOW_FLAG = 6;
  localparam int CTL_LOW_IRQ_EN = 5;
  localparam int CTL_CAPTURE_EN = 4;
  localparam int CTL_SPLIT = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_XCLK_MSB = 1;
  localparam int CTL_XCLK_LSB = 0;

  // Clock control register fields
  localparam int CKC_LOW_SEL = 0;
  localparam int CKC_HIGH_SEL = 1;
  localparam int CKC_TIMER_IRQ_EN = 2;
  localparam int CKC_WIDTH = 3;

  // Interrupt status and mask fields
  localparam int IRQ_HIGH = 0;
  localparam int IRQ_LOW = 1;
  localparam int IRQ_WIDTH = 2;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] CLOCK_CONTROL_RESET = 3'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // External clock select encodings
  localparam logic [1:0] XCLK_SYS_DIV = 2'h0;
  localparam logic [1:0] XCLK_RTC_DIV = 2'h1;
  localparam logic [1:0] XCLK_RESERVED = 2'h2;
  localparam logic [1:0] XCLK_COMPARATOR = 2'h3;

  // Divider counts
  localparam int SYS_DIVIDE = 12;
  localparam int RTC_DIVIDE = 8;

  // Wrap values
  localparam logic [7:0] BYTE_MAX = 8'hff;

  // External tick for one half, shared by both halves
  function automatic logic ext_tick(input logic [1:0] xclk, input logic sys_div,
                                    input logic rtc_div, input logic comp_rise);
    case (xclk)
      XCLK_SYS_DIV: ext_tick = sys_div;
      XCLK_RTC_DIV: ext_tick = rtc_div;
      XCLK_COMPARATOR: ext_tick = comp_rise;
      default: ext_tick = 1'b0; // Reserved code never advances
    endcase
  endfunction : ext_tick

endpackage : split_timer_pkg

// ---- hdl/clock_source_sync.sv ----
// Synchronisers and dividers producing one-cycle count ticks for the timer
`timescale 1ns/1ps
`default_nettype none
module clock_source_sync #(
  parameter int SYS_DIV = split_timer_pkg::SYS_DIVIDE,
  parameter int RTC_DIV = split_timer_pkg::RTC_DIVIDE
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic rtc_osc_in,
  input wire logic comparator_in,
  output logic sys_div_tick_out,
  output logic rtc_div_tick_out,
  output logic comp_rise_tick_out
);

  localparam int SW = $clog2(SYS_DIV);
  localparam int RW = $clog2(RTC_DIV);
  localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
  localparam logic [RW-1:0] RTC_LAST = RW'(RTC_DIV - 1);

  logic [1:0] rtc_sync; // Two-stage synchroniser, stage 0 read only by stage 1
  logic [1:0] comp_sync; // Same for the comparator
  logic rtc_prev; // Previous synchronised level for edge detection
  logic comp_prev;
  logic [SW-1:0] sys_cnt; // System clock prescaler
  logic [RW-1:0] rtc_cnt; // Counts oscillator rising edges
  logic next_rtc_prev;
  logic next_comp_prev;
  logic [SW-1:0] next_sys_cnt;
  logic [RW-1:0] next_rtc_cnt;
  logic next_sys_tick;
  logic next_rtc_tick;
  logic next_comp_tick;
  logic rtc_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state: edge detection and dividers on synchronised levels only
  always_comb begin
    rtc_rise = rtc_sync[1] & ~rtc_prev;
    next_rtc_prev = rtc_sync[1];
    next_comp_prev = comp_sync[1];
    next_sys_tick = (sys_cnt == SYS_LAST);
    next_sys_cnt = next_sys_tick ? '0 : sys_cnt + SW'(1);
    next_rtc_tick = rtc_rise & (rtc_cnt == RTC_LAST);
    next_rtc_cnt = rtc_cnt;
    if (rtc_rise) begin
      next_rtc_cnt = (rtc_cnt == RTC_LAST) ? '0 : rtc_cnt + RW'(1);
    end
    next_comp_tick = comp_sync[1] & ~comp_prev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; async inputs enter through two flops before any logic
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rtc_sync <= 2'h0;
      comp_sync <= 2'h0;
      rtc_prev <= 1'b0;
      comp_prev <= 1'b0;
      sys_cnt <= '0;
      rtc_cnt <= '0;
      sys_div_tick_out <= 1'b0;
      rtc_div_tick_out <= 1'b0;
      comp_rise_tick_out <= 1'b0;
    end else begin
      rtc_sync <= {rtc_sync[0], rtc_osc_in}; // R4
      comp_sync <= {comp_sync[0], comparator_in}; // R4
      rtc_prev <= next_rtc_prev;
      comp_prev <= next_comp_prev;
      sys_cnt <= next_sys_cnt; // R3
      rtc_cnt <= next_rtc_cnt; // R3
      sys_div_tick_out <= next_sys_tick;
      rtc_div_tick_out <= next_rtc_tick;
      comp_rise_tick_out <= next_comp_tick;
    end
  end

  // Prescaler tick spacing
  AST_SYS_DIV_SPACING: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(sys_div_tick_out) |=> !sys_div_tick_out [*8]) // R3
    else $error("System clock prescaler ticked too early");

endmodule : clock_source_sync
`default_nettype wire

// ---- hdl/split_reload_capture_timer.sv ----
// Split 16-bit auto-reload timer with capture mode and an APB register slave
//
// Function
// [R1] 16-bit counter of two 8-bit halves
// [R2] 16-bit wrap reloads pair, sets high flag
// [R3] Four count sources selectable
// [R4] Oscillator and comparator synchronised first
// [R5] Interrupt on 16-bit overflow when enabled
// [R6] Optional interrupt on low byte wrap
// [R7] Split halves reload independently
// [R8] Split: run bit gates only high half
// [R9] Per-half select: system clock or external
// [R10] Split: each half wrap sets its flag
// [R11] Split interrupts: high, or either half
// [R12] Flags cleared only by software
// [R13] Software enables capture, keeps 16-bit mode
// [R14] Capture on comparator rise or oscillator/8
// [R15] Capture copies count, sets high flag
// [R16] Software derives period from capture differences
// [R17] Control register layout, resets to zero
// [R18] Reserved external select halts that half
`timescale 1ns/1ps
`default_nettype none
module split_reload_capture_timer #(
  parameter int SYS_DIV = split_timer_pkg::SYS_DIVIDE,
  parameter int RTC_DIV = split_timer_pkg::RTC_DIVIDE
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic rtc_osc_in,
  input wire logic comparator_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] timer_control_reg; // Flags, enables, split, run, ext select
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;
  logic [2:0] clock_control_reg; // Half selects and timer interrupt enable
  logic [1:0] irq_status; // Sticky, cleared by reading
  logic [1:0] irq_mask;
  logic [7:0] next_control;
  logic [7:0] next_count_low;
  logic [7:0] next_count_high;
  logic [7:0] next_reload_low;
  logic [7:0] next_reload_high;
  logic [2:0] next_clock_control;
  logic [1:0] next_irq_status;
  logic [1:0] next_irq_mask;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;

  // Ticks from the synchroniser block
  logic sys_div_tick;
  logic rtc_div_tick;
  logic comp_rise_tick;

  // Decoded controls
  logic split_select;
  logic run_control;
  logic capture_enable;
  logic low_byte_irq_enable;
  logic [1:0] external_clock_select;
  logic low_half_clock_select;
  logic high_half_clock_select;
  logic timer_irq_enable;
  logic tick_low; // Low half (or whole 16-bit counter) advances
  logic tick_high; // High half advances in split mode
  logic capture_event;
  logic wrap_low; // Low byte wraps from 0xFF (to 0x00 or its reload) this cycle
  logic wrap_high; // High half or whole counter wraps this cycle
  logic apb_done; // Access phase completes on this edge
  logic wr_en;
  logic rd_en;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Count source synchronisers and dividers
  clock_source_sync #(
    .SYS_DIV(SYS_DIV),
    .RTC_DIV(RTC_DIV)
  ) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .rtc_osc_in(rtc_osc_in),
    .comparator_in(comparator_in),
    .sys_div_tick_out(sys_div_tick),
    .rtc_div_tick_out(rtc_div_tick),
    .comp_rise_tick_out(comp_rise_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Field decode and count enables
  assign split_select = timer_control_reg[split_timer_pkg::CTL_SPLIT];
  assign run_control = timer_control_reg[split_timer_pkg::CTL_RUN];
  assign capture_enable = timer_control_reg[split_timer_pkg::CTL_CAPTURE_EN];
  assign low_byte_irq_enable = timer_control_reg[split_timer_pkg::CTL_LOW_IRQ_EN];
  assign external_clock_select =
    timer_control_reg[split_timer_pkg::CTL_XCLK_MSB:split_timer_pkg::CTL_XCLK_LSB];
  assign low_half_clock_select = clock_control_reg[split_timer_pkg::CKC_LOW_SEL];
  assign high_half_clock_select = clock_control_reg[split_timer_pkg::CKC_HIGH_SEL];
  assign timer_irq_enable = clock_control_reg[split_timer_pkg::CKC_TIMER_IRQ_EN];

  // Select 1 picks every system clock, 0 the shared external select
  assign tick_low = low_half_clock_select | split_timer_pkg::ext_tick( // R9 R18
    external_clock_select, sys_div_tick, rtc_div_tick, comp_rise_tick);
  assign tick_high = high_half_clock_select | split_timer_pkg::ext_tick( // R9 R18
    external_clock_select, sys_div_tick, rtc_div_tick, comp_rise_tick);

  // Capture source chosen by the upper external select bit
  assign capture_event = capture_enable &
    (external_clock_select[1] ? comp_rise_tick : rtc_div_tick); // R14

  // Low half free-runs in split mode; 16-bit mode obeys run control
  assign wrap_low = (count_low_byte == split_timer_pkg::BYTE_MAX) &
    tick_low & (split_select | run_control); // R8
  assign wrap_high = split_select ?
    (run_control & tick_high & (count_high_byte == split_timer_pkg::BYTE_MAX)) : // R8 R10
    (wrap_low & (count_high_byte == split_timer_pkg::BYTE_MAX)); // R2

  // APB: pready is registered in the setup cycle, so every access completes with no wait state
  assign apb_done = psel_in & penable_in & pready_out;
  assign wr_en = apb_done & pwrite_in;
  assign rd_en = apb_done & ~pwrite_in;

  // Address decode for the error answer; the read mux has its own case
  always_comb begin
    case (paddr_in)
      split_timer_pkg::OFF_CONTROL, split_timer_pkg::OFF_COUNT_LOW,
      split_timer_pkg::OFF_COUNT_HIGH, split_timer_pkg::OFF_RELOAD_LOW,
      split_timer_pkg::OFF_RELOAD_HIGH, split_timer_pkg::OFF_CLOCK_CONTROL,
      split_timer_pkg::OFF_IRQ_STATUS, split_timer_pkg::OFF_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state for counter, reload, flags, interrupts and bus answer
  always_comb begin
    next_control = timer_control_reg;
    next_count_low = count_low_byte;
    next_count_high = count_high_byte;
    next_reload_low = reload_low_byte;
    next_reload_high = reload_high_byte;
    next_clock_control = clock_control_reg;
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;

    // Counting
    if (split_select) begin
      if (tick_low) begin
        next_count_low = wrap_low ? reload_low_byte : count_low_byte + 8'h01; // R7 R8
      end
      if (run_control & tick_high) begin
        next_count_high = wrap_high ? reload_high_byte : count_high_byte + 8'h01; // R7
      end
    end else if (run_control & tick_low) begin
      if (wrap_high) begin
        next_count_low = reload_low_byte; // R2
        next_count_high = reload_high_byte; // R2
      end else begin
        next_count_low = count_low_byte + 8'h01; // R1
        next_count_high = wrap_low ? count_high_byte + 8'h01 : count_high_byte; // R1
      end
    end

    // Software writes; flag writes may clear, hardware sets below win
    if (wr_en) begin
      case (paddr_in)
        split_timer_pkg::OFF_CONTROL: next_control = pwdata_in[7:0]; // R17
        split_timer_pkg::OFF_COUNT_LOW: next_count_low = pwdata_in[7:0];
        split_timer_pkg::OFF_COUNT_HIGH: next_count_high = pwdata_in[7:0];
        split_timer_pkg::OFF_RELOAD_LOW: next_reload_low = pwdata_in[7:0];
        split_timer_pkg::OFF_RELOAD_HIGH: next_reload_high = pwdata_in[7:0];
        split_timer_pkg::OFF_CLOCK_CONTROL:
          next_clock_control = pwdata_in[split_timer_pkg::CKC_WIDTH-1:0];
        split_timer_pkg::OFF_IRQ_MASK: next_irq_mask = pwdata_in[1:0];
        default: ; // Status is read-only, others unmapped
      endcase
    end

    // Capture overrides a reload write landing on the same edge
    if (capture_event) begin
      next_reload_low = count_low_byte; // R15
      next_reload_high = count_high_byte; // R15
    end

    // Flags only ever set by hardware, never cleared here
    if (wrap_low) begin
      next_control[split_timer_pkg::CTL_LOW_FLAG] = 1'b1; // R10 R12
    end
    if (wrap_high | capture_event) begin
      next_control[split_timer_pkg::CTL_HIGH_FLAG] = 1'b1; // R2 R10 R15 R12
    end

    // Sticky status: read clears, a new event on that edge still sets
    if (rd_en && paddr_in == split_timer_pkg::OFF_IRQ_STATUS) begin
      next_irq_status = split_timer_pkg::IRQ_RESET;
    end
    if (timer_irq_enable & (wrap_high | capture_event)) begin
      next_irq_status[split_timer_pkg::IRQ_HIGH] = 1'b1; // R5 R11 R15
    end
    if (timer_irq_enable & low_byte_irq_enable & wrap_low) begin
      next_irq_status[split_timer_pkg::IRQ_LOW] = 1'b1; // R6 R11
    end
    next_irq = |(next_irq_status & next_irq_mask);

    // Bus answer prepared in the setup cycle
    next_pready = psel_in & ~penable_in;
    next_pslverr = psel_in & ~penable_in & ~mapped;
    next_prdata = 32'h0000_0000;
    if (psel_in & ~penable_in) begin
      case (paddr_in)
        split_timer_pkg::OFF_CONTROL: next_prdata[7:0] = timer_control_reg;
        split_timer_pkg::OFF_COUNT_LOW: next_prdata[7:0] = count_low_byte;
        split_timer_pkg::OFF_COUNT_HIGH: next_prdata[7:0] = count_high_byte;
        split_timer_pkg::OFF_RELOAD_LOW: next_prdata[7:0] = reload_low_byte;
        split_timer_pkg::OFF_RELOAD_HIGH: next_prdata[7:0] = reload_high_byte;
        split_timer_pkg::OFF_CLOCK_CONTROL: next_prdata[2:0] = clock_control_reg;
        split_timer_pkg::OFF_IRQ_STATUS: next_prdata[1:0] = irq_status;
        split_timer_pkg::OFF_IRQ_MASK: next_prdata[1:0] = irq_mask;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_control_reg <= split_timer_pkg::CONTROL_RESET; // R17
      count_low_byte <= split_timer_pkg::BYTE_RESET;
      count_high_byte <= split_timer_pkg::BYTE_RESET;
      reload_low_byte <= split_timer_pkg::BYTE_RESET;
      reload_high_byte <= split_timer_pkg::BYTE_RESET;
      clock_control_reg <= split_timer_pkg::CLOCK_CONTROL_RESET;
      irq_status <= split_timer_pkg::IRQ_RESET;
      irq_mask <= split_timer_pkg::IRQ_RESET;
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      timer_control_reg <= next_control;
      count_low_byte <= next_count_low;
      count_high_byte <= next_count_high;
      reload_low_byte <= next_reload_low;
      reload_high_byte <= next_reload_high;
      clock_control_reg <= next_clock_control;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      prdata_out <= next_prdata;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
      irq_out <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic sw_count_wr; // Software touching count or reload bytes
  assign sw_count_wr = wr_en & (paddr_in == split_timer_pkg::OFF_COUNT_LOW |
    paddr_in == split_timer_pkg::OFF_COUNT_HIGH | paddr_in == split_timer_pkg::OFF_RELOAD_LOW |
    paddr_in == split_timer_pkg::OFF_RELOAD_HIGH);

  AST_WRAP16_RELOAD: assert property (@(posedge clk_in) disable iff (!nrst_in) // R2
    !split_select && run_control && tick_low && !sw_count_wr && !capture_event &&
    {count_high_byte, count_low_byte} == 16'hffff
    |=> {count_high_byte, count_low_byte} == $past({reload_high_byte, reload_low_byte}) &&
        timer_control_reg[split_timer_pkg::CTL_HIGH_FLAG])
    else $error("16-bit wrap did not reload or flag");

  AST_COUNT16_INC: assert property (@(posedge clk_in) disable iff (!nrst_in) // R1
    !split_select && run_control && tick_low && !sw_count_wr &&
    {count_high_byte, count_low_byte} != 16'hffff
    |=> {count_high_byte, count_low_byte} == $past({count_high_byte, count_low_byte}) + 16'h0001)
    else $error("16-bit counter did not increment");

  AST_SPLIT_LOW_FREE: assert property (@(posedge clk_in) disable iff (!nrst_in) // R8
    split_select && !run_control && tick_low && !sw_count_wr &&
    count_low_byte != split_timer_pkg::BYTE_MAX
    |=> count_low_byte == $past(count_low_byte) + 8'h01)
    else $error("Low half stopped while split and run off");

  AST_SPLIT_HIGH_HOLD: assert property (@(posedge clk_in) disable iff (!nrst_in) // R8
    split_select && !run_control && !sw_count_wr |=> $stable(count_high_byte))
    else $error("High half moved with run control off");

  AST_SPLIT_HIGH_WRAP: assert property (@(posedge clk_in) disable iff (!nrst_in) // R7
    split_select && run_control && tick_high && !sw_count_wr && !capture_event &&
    count_high_byte == split_timer_pkg::BYTE_MAX
    |=> count_high_byte == $past(reload_high_byte) &&
        timer_control_reg[split_timer_pkg::CTL_HIGH_FLAG])
    else $error("High half wrap did not reload or flag");

  AST_CAPTURE_COPY: assert property (@(posedge clk_in) disable iff (!nrst_in) // R15
    capture_event
    |=> {reload_high_byte, reload_low_byte} == $past({count_high_byte, count_low_byte}) &&
        timer_control_reg[split_timer_pkg::CTL_HIGH_FLAG])
    else $error("Capture did not copy count or set flag");

  AST_FLAG_STICKY: assert property (@(posedge clk_in) disable iff (!nrst_in) // R12
    timer_control_reg[split_timer_pkg::CTL_LOW_FLAG] &&
    !(wr_en && paddr_in == split_timer_pkg::OFF_CONTROL)
    |=> timer_control_reg[split_timer_pkg::CTL_LOW_FLAG])
    else $error("Low flag cleared without software");

  // Low half on the reserved source holds in both modes; 16-bit mode moves only via low
  AST_RESERVED_HALT: assert property (@(posedge clk_in) disable iff (!nrst_in) // R18
    !low_half_clock_select &&
    external_clock_select == split_timer_pkg::XCLK_RESERVED && !sw_count_wr
    |=> $stable(count_low_byte))
    else $error("Counter advanced on reserved source");

  AST_IRQ_ON_WRAP: assert property (@(posedge clk_in) disable iff (!nrst_in) // R5
    timer_irq_enable && wrap_high && irq_mask[split_timer_pkg::IRQ_HIGH] &&
    !(wr_en && paddr_in == split_timer_pkg::OFF_IRQ_MASK) |=> irq_out)
    else $error("Overflow did not raise interrupt");

  AST_APB_ANSWER: assert property (@(posedge clk_in) disable iff (!nrst_in)
    psel_in && !penable_in |=> pready_out && (pslverr_out == !$past(mapped)))
    else $error("APB answer missing after setup");

  COV_WRAP16: cover property (@(posedge clk_in) disable iff (!nrst_in)
    !split_select && wrap_high);
  COV_SPLIT_BOTH: cover property (@(posedge clk_in) disable iff (!nrst_in)
    split_select && wrap_low ##[1:600] wrap_high);
  COV_CAPTURE_TWICE: cover property (@(posedge clk_in) disable iff (!nrst_in)
    capture_event ##[1:900] capture_event);
  COV_IRQ: cover property (@(posedge clk_in) disable iff (!nrst_in) $rose(irq_out));

endmodule : split_reload_capture_timer
`default_nettype wire

// ---- test/split_reload_capture_timer_tb_top.sv ----
// Testbench: APB register scenarios for the split reload capture timer
`timescale 1ns/1ps
`default_nettype none
module split_reload_capture_timer_tb_top;
  ////////////////////////////////////////////////////////////////////////
  logic clk_in = 1'b0; // 50 MHz system clock
  logic nrst_in = 1'b0; // Held low for ten cycles
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic rtc = 1'b0; // Slow oscillator, pulsed only where a test needs it
  logic comp = 1'b0; // Comparator level
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  int fails = 0;
  int comparisons = 0;
  logic [31:0] q;
  logic e;
  logic [15:0] cap; // First captured count, then the expected second one
  time t0; // Edges at which the comparator rises are driven
  time t1;

  // Clock: toggles every half period
  always #10 clk_in = ~clk_in;

  split_reload_capture_timer split_reload_capture_timer_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
    .rtc_osc_in(rtc), .comparator_in(comp), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run, shared with the watchdog
  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask : rc

  // Bounded wait for the interrupt line
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clk_in);
      n++;
    end
    chk({31'h0, irq}, 32'h0000_0001);
  endtask : wait_irq

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: tests take a few thousand cycles at most
  initial begin
    #(20 * 20000);
    fails++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 8; i++) rc(8'(i * 4), 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    wr(split_timer_pkg::OFF_IRQ_STATUS, 32'h0000_0003);
    rc(split_timer_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
    $display("test reset and map done");
    // Sixteen-bit wrap from FFFF reloads the pair
    wr(split_timer_pkg::OFF_RELOAD_HIGH, 32'h0000_0012);
    wr(split_timer_pkg::OFF_RELOAD_LOW, 32'h0000_0034);
    wr(split_timer_pkg::OFF_COUNT_HIGH, 32'h0000_00ff);
    wr(split_timer_pkg::OFF_COUNT_LOW, 32'h0000_00f0);
    wr(split_timer_pkg::OFF_CLOCK_CONTROL, 32'h0000_0005);
    wr(split_timer_pkg::OFF_IRQ_MASK, 32'h0000_0003);
    wr(split_timer_pkg::OFF_CONTROL, 32'h0000_0004);
    wait_irq();
    rc(split_timer_pkg::OFF_COUNT_HIGH, 32'h0000_0012);
    rc(split_timer_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    rc(split_timer_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    rc(split_timer_pkg::OFF_CONTROL, 32'h0000_00c4);
    wr(split_timer_pkg::OFF_CONTROL, 32'h0000_0004);
    rc(split_timer_pkg::OFF_CONTROL, 32'h0000_0004);
    $display("test wide wrap done");
    // Low byte wrap interrupt in wide mode
    wr(split_timer_pkg::OFF_COUNT_HIGH, 32'h0000_0000);
    wr(split_timer_pkg::OFF_COUNT_LOW, 32'h0000_00fe);
    wr(split_timer_pkg::OFF_CONTROL, 32'h0000_0024);
    wait_irq();
    rc(split_timer_pkg::OFF_IRQ_STATUS, 32'h0000_0002);
    rc(split_timer_pkg::OFF_CONTROL, 32'h0000_0064);
    $display("test low byte irq done");
    // Split, run clear: low half counts and reloads, high half stands
    wr(split_timer_pkg::OFF_CONTROL, 32'h0000_0028);
    wr(split_timer_pkg::OFF_COUNT_HIGH, 32'h0000_0077);
    wr(split_timer_pkg::OFF_RELOAD_LOW, 32'h0000_0090);
    wr(split_timer_pkg::OFF_COUNT_LOW, 32'h0000_00f0);
    wait_irq();
    rc(split_timer_pkg::OFF_COUNT_HIGH, 32'h0000_0077);
    rc(split_timer_pkg::OFF_IRQ_STATUS, 32'h0000_0002);
    rc(split_timer_pkg::OFF_CONTROL, 32'h0000_0068);
    // Split with run set: high half on system clock overflows
    wr(split_timer_pkg::OFF_CLOCK_CONTROL, 32'h0000_0007);
    wr(split_timer_pkg::OFF_COUNT_HIGH, 32'h0000_00ff);
    wr(split_timer_pkg::OFF_CONTROL, 32'h0000_000c);
    wait_irq();
    rc(split_timer_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    $display("test split halves done");
    // Reserved external select: low half must hold still
    wr(split_timer_pkg::OFF_CLOCK_CONTROL, 32'h0000_0004);
    wr(split_timer_pkg::OFF_CONTROL, 32'h0000_000a);
    wr(split_timer_pkg::OFF_COUNT_LOW, 32'h0000_0055);
    repeat (30) @(posedge clk_in);
    rc(split_timer_pkg::OFF_COUNT_LOW, 32'h0000_0055);
    // Oscillator over eight: sixteen rises give two counts
    wr(split_timer_pkg::OFF_CONTROL, 32'h0000_0009);
    wr(split_timer_pkg::OFF_COUNT_LOW, 32'h0000_0000);
    repeat (32) begin
      repeat (5) @(posedge clk_in);
      rtc <= ~rtc;
    end
    repeat (10) @(posedge clk_in);
    rc(split_timer_pkg::OFF_COUNT_LOW, 32'h0000_0002);
    $display("test clock sources done");
    // Capture on comparator rise copies the running count
    wr(split_timer_pkg::OFF_CONTROL, 32'h0000_0000);
    wr(split_timer_pkg::OFF_CLOCK_CONTROL, 32'h0000_0005);
    wr(split_timer_pkg::OFF_COUNT_HIGH, 32'h0000_0010);
    wr(split_timer_pkg::OFF_COUNT_LOW, 32'h0000_0000);
    wr(split_timer_pkg::OFF_RELOAD_HIGH, 32'h0000_0000);
    wr(split_timer_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    wr(split_timer_pkg::OFF_CONTROL, 32'h0000_0017);
    @(posedge clk_in);
    comp <= 1'b1;
    t0 = $time;
    wait_irq();
    rc(split_timer_pkg::OFF_RELOAD_HIGH, 32'h0000_0010);
    apb(1'b0, split_timer_pkg::OFF_RELOAD_LOW, 32'h0000_0000, q, e);
    cap = {8'h10, q[7:0]};
    rc(split_timer_pkg::OFF_CONTROL, 32'h0000_0097);
    rc(split_timer_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    // Second rise: captures differ by the clock cycles between rises
    comp <= 1'b0;
    repeat (20) @(posedge clk_in);
    comp <= 1'b1;
    t1 = $time;
    wait_irq();
    cap = cap + 16'((t1 - t0) / 20);
    rc(split_timer_pkg::OFF_RELOAD_LOW, {24'h0, cap[7:0]});
    rc(split_timer_pkg::OFF_RELOAD_HIGH, {24'h0, cap[15:8]});
    rc(split_timer_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    // Oscillator over eight as capture source: eight rises, one capture
    wr(split_timer_pkg::OFF_CONTROL, 32'h0000_0015);
    repeat (16) begin
      repeat (5) @(posedge clk_in);
      rtc <= ~rtc;
    end
    wait_irq();
    rc(split_timer_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    $display("test capture done");
    tally_and_finish();
  end
endmodule : split_reload_capture_timer_tb_top
`default_nettype wire
